// >>> design/region_check.sv
/*
 * Combinational region check: classifies one address against the product
 * region map. Assumes the map fields are ordered as named.
 */
`timescale 1ns/100ps

module region_check (
	// address and map
	input  wire logic [19:0]                 addr_i,
	input  wire guard_pkg::region_map_type  map_i,
	// classification
	output logic                             invalid_o,
	output logic                             flash_gap_o
);

	// ------------------------------------------------------------
	// classification
	// ------------------------------------------------------------
	// gap between flash end and the 64K or 128K boundary
	assign flash_gap_o = (addr_i > map_i.flash_end) && (addr_i <= map_i.gap_top);

	always_comb begin
		invalid_o = 1'b0;
		// data flash is real memory even where the mirror span covers it
		if (addr_i > map_i.flash_end && addr_i <= map_i.mirror_end &&
			!(addr_i >= map_i.data_flash_start && addr_i < map_i.data_flash_end)) begin
			invalid_o = 1'b1;
		end
		// hole between the end of data flash and the start of ram
		if (addr_i >= map_i.data_flash_end && addr_i < map_i.ram_start) begin
			invalid_o = 1'b1;
		end
	end

endmodule

// >>> design/sfr_guard.sv
/*
 * Special function register write guard and invalid memory access detector.
 * Sits between the CPU and the register bus; assumes one access per cycle,
 * synchronous to clock_i, and that a reset request resets the whole chip.
 */
// Functional notes
// - With the port guard set, writes to port configuration registers are dropped.
// - With the irq guard set, writes to interrupt flag, mask, priority and edge registers are dropped.
// - With the clock/voltage guard set, writes to clock and voltage detector registers are dropped.
// - All three guard bits are zero after reset.
// - The control register reads 00h after reset and takes byte accesses only.
// - With detection enabled, any access into the invalid space requests a reset.
// - The detect enable bit can only be set by software, never cleared before reset.
// - Option byte bit four forces detection on whatever the enable bit holds.
// - Small flash parts read FFh from the flash gap up to the 64K boundary.
// - 96K flash parts read FFh from the flash gap up to the 128K boundary.
// - A fetch from the flash gap requests a reset.
`timescale 1ns/100ps

module sfr_guard #(
	parameter int unsigned          NUM_GUARDED = 4,
	parameter logic [19:0]          FLASH_END = 20'h0bfff,
	parameter logic [19:0]          GAP_TOP = guard_pkg::FLASH_GAP_TOP_64K,
	parameter logic [19:0]          MIRROR_END = 20'hf1fff,
	parameter logic [19:0]          DATA_FLASH_START = 20'hf1000,
	parameter logic [19:0]          DATA_FLASH_END = 20'hf2000,
	parameter logic [19:0]          RAM_START = 20'hff300,
	parameter logic [NUM_GUARDED-1:0][19:0] GUARD_ADDR = {20'hfffe0, 20'hfffd0,
		20'hf00f0, 20'hfff20},
	parameter guard_pkg::reg_group_type [NUM_GUARDED-1:0] GUARD_GROUP = '{
		guard_pkg::GROUP_IRQ, guard_pkg::GROUP_IRQ,
		guard_pkg::GROUP_CLKV, guard_pkg::GROUP_PORT}
) (
	// clock and reset
	input  wire logic                       clock_i,
	input  wire logic                       reset_n_i,
	// cpu side
	input  wire guard_pkg::cpu_access_type  cpu_i,
	input  wire logic [7:0]                 option_byte_i,
	// register bus side
	output logic                            reg_write_o,
	output logic [19:0]                     reg_addr_o,
	output logic [7:0]                      reg_wdata_o,
	// read override and control readback
	output logic                            read_override_o,
	output logic [7:0]                      read_data_o,
	// reset request and status
	output logic                            reset_request_o,
	output logic [7:0]                      guard_ctrl_o
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  ctrl;
		logic        reg_write;
		logic [19:0] reg_addr;
		logic [7:0]  reg_wdata;
		logic        read_override;
		logic [7:0]  read_data;
		logic        reset_request;
	} state_type;

	state_type state_q;
	state_type state_d;

	guard_pkg::region_map_type map;
	logic                      region_invalid;
	logic                      flash_gap;
	logic [NUM_GUARDED-1:0]    hit_blocked;
	logic                      detect_active;
	logic                      ctrl_hit;
	// access classes, decoded once for the write, gap read and gap fetch rules below
	logic                      write_req;
	logic                      read_req;
	logic                      fetch_req;
	logic                      any_guard_hit;

	assign map = '{flash_end: FLASH_END, gap_top: GAP_TOP, mirror_end: MIRROR_END,
		data_flash_start: DATA_FLASH_START, data_flash_end: DATA_FLASH_END,
		ram_start: RAM_START};

	region_check u_region (
		.addr_i      (cpu_i.addr),
		.map_i       (map),
		.invalid_o   (region_invalid),
		.flash_gap_o (flash_gap)
	);

	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	// a fetch is never a data read, so gap reads and gap fetches stay apart
	assign write_req = cpu_i.valid & cpu_i.write;
	assign read_req = cpu_i.valid & ~cpu_i.write & ~cpu_i.fetch;
	assign fetch_req = cpu_i.valid & cpu_i.fetch;

	// ------------------------------------------------------------
	// guarded register match
	// ------------------------------------------------------------
	// per-entry group guard
	// each entry names one register and the group bit that locks it; an
	// entry of no group is never locked, so spare slots cost nothing
	genvar gi;
	generate
		for (gi = 0; gi < NUM_GUARDED; gi++) begin : g_match
			logic addr_match;
			logic group_locked;

			// exact compare: a partial decode would lock neighbouring registers
			assign addr_match = (cpu_i.addr == GUARD_ADDR[gi]);

			// group bit that governs this entry
			always_comb begin
				group_locked = 1'b0;
				unique case (GUARD_GROUP[gi])
					guard_pkg::GROUP_PORT: begin
						group_locked = state_q.ctrl[guard_pkg::BIT_PORT_GUARD];
					end
					guard_pkg::GROUP_IRQ: begin
						group_locked = state_q.ctrl[guard_pkg::BIT_IRQ_GUARD];
					end
					guard_pkg::GROUP_CLKV: begin
						group_locked = state_q.ctrl[guard_pkg::BIT_CLKV_GUARD];
					end
					guard_pkg::GROUP_NONE: begin
						group_locked = 1'b0;
					end
				endcase
			end

			// one continuous driver per bit of the hit vector
			assign hit_blocked[gi] = addr_match & group_locked;
		end
	endgenerate

	// any locked entry that matches drops the write
	assign any_guard_hit = |hit_blocked;

	// detection on by enable bit or option strap
	assign detect_active = state_q.ctrl[guard_pkg::BIT_DETECT_EN]
		| option_byte_i[guard_pkg::OPTION_FORCE_BIT];
	// byte accesses only reach the control register
	assign ctrl_hit = cpu_i.valid && cpu_i.byte_access
		&& (cpu_i.addr == guard_pkg::GUARD_CTRL_ADDR);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// pulses fall back low every cycle; the address and data copies follow
	// the bus each cycle so the register side sees them with a fixed lag
	always_comb begin
		state_d = state_q;
		state_d.reg_write = 1'b0;
		state_d.read_override = 1'b0;
		state_d.reset_request = 1'b0;
		state_d.reg_addr = cpu_i.addr;
		state_d.reg_wdata = cpu_i.wdata;
		state_d.read_data = guard_pkg::UNFILLED_READ_DATA;

		// ordinary writes pass unless a locked entry matches
		if (write_req && !ctrl_hit) begin
			state_d.reg_write = ~any_guard_hit;
		end

		// control register write
		if (ctrl_hit && cpu_i.write) begin
			// enable bit is sticky once set
			state_d.ctrl = (cpu_i.wdata & guard_pkg::GUARD_CTRL_MASK)
				| (state_q.ctrl & (8'h01 << guard_pkg::BIT_DETECT_EN));
		end
		if (ctrl_hit && !cpu_i.write) begin
			state_d.read_override = 1'b1;
			state_d.read_data = state_q.ctrl;
		end
		// gap reads are answered here, so nothing is needed behind the gap
		if (read_req && flash_gap) begin
			state_d.read_override = 1'b1;
		end
		// fetch from gap decodes as invalid instruction
		// this reset does not wait for the detect enable: the core would
		// otherwise run all-ones bytes as code
		if (fetch_req && flash_gap) begin
			state_d.reset_request = 1'b1;
		end
		// invalid space access requests reset
		// one pulse per offending access; the chip reset logic stretches it
		if (cpu_i.valid && detect_active && region_invalid) begin
			state_d.reset_request = 1'b1;
		end
	end

	// guard bits and register cleared at reset
	// bus copies reset to zero and read data to all ones, the idle values,
	// so nothing downstream sees a stray pulse while reset is let go
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q <= '0;
			state_q.ctrl <= guard_pkg::GUARD_CTRL_RESET;
			state_q.read_data <= guard_pkg::UNFILLED_READ_DATA;
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// outputs, all registered
	// ------------------------------------------------------------
	// plain wires from the state register, no logic after the flops
	assign reg_write_o = state_q.reg_write;
	assign reg_addr_o = state_q.reg_addr;
	assign reg_wdata_o = state_q.reg_wdata;
	assign read_override_o = state_q.read_override;
	assign read_data_o = state_q.read_data;
	assign reset_request_o = state_q.reset_request;
	assign guard_ctrl_o = state_q.ctrl;

endmodule

// >>> include/guard_pkg.sv
/*
 * Package for the register write guard and invalid access detector.
 * Assumes a 20-bit CPU address space and byte-wide register data.
 */
package guard_pkg;

	// ------------------------------------------------------------
	// address map and control register
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 20;
	localparam logic [19:0] GUARD_CTRL_ADDR = 20'hf0078;
	localparam logic [7:0]  GUARD_CTRL_RESET = 8'h00;
	localparam logic [19:0] FLASH_GAP_TOP_64K = 20'h0ffff;
	localparam logic [19:0] FLASH_GAP_TOP_128K = 20'h1ffff;
	localparam logic [7:0]  UNFILLED_READ_DATA = 8'hff;

	// control register bit positions
	localparam int unsigned BIT_DETECT_EN = 7;
	localparam int unsigned BIT_PORT_GUARD = 2;
	localparam int unsigned BIT_IRQ_GUARD = 1;
	localparam int unsigned BIT_CLKV_GUARD = 0;
	// writable bits of the control register (ram guard field left out)
	localparam logic [7:0]  GUARD_CTRL_MASK = 8'h87;

	// option byte bit that forces detection on
	localparam int unsigned OPTION_FORCE_BIT = 4;

	// register group codes for guarded register tables
	typedef enum logic [1:0] {
		GROUP_NONE,
		GROUP_PORT,
		GROUP_IRQ,
		GROUP_CLKV
	} reg_group_type;

	// one CPU access as seen by the guard
	typedef struct packed {
		logic              valid;
		logic              write;
		logic              fetch;
		logic              byte_access;
		logic [19:0]       addr;
		logic [7:0]        wdata;
	} cpu_access_type;

	// per-product region boundaries
	typedef struct packed {
		logic [19:0] flash_end;
		logic [19:0] gap_top;
		logic [19:0] mirror_end;
		logic [19:0] data_flash_start;
		logic [19:0] data_flash_end;
		logic [19:0] ram_start;
	} region_map_type;

endpackage

// >>> tb/cpu_model.sv
/* cpu model: one access at a time
   assumes callers wait for the task to end */
`timescale 1ns/100ps
module cpu_model (
	// clock and access out
	input  wire logic                clock_i,
	output guard_pkg::cpu_access_type cpu_o
);
	initial cpu_o = '0;
	// held over the taking edge, then released to inverted data
	task automatic acc(input logic w, f, b, input logic [19:0] a, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		cpu_o = '{valid: 1'b1, write: w, fetch: f, byte_access: b, addr: a, wdata: d};
		@(posedge clock_i);
		#1;
		cpu_o = '{valid: 1'b0, write: ~w, fetch: ~f, byte_access: ~b, addr: ~a, wdata: ~d};
	endtask
endmodule

// >>> tb/sfr_guard_and_invalid_access_detect_bench.sv
/* bench for the guard: corner and random accesses
   assumes the design defaults for table and regions */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module sfr_guard_and_invalid_access_detect_bench;
	logic                      clock_i = 1'b0;
	logic                      reset_n_i = 1'b0;
	logic [7:0]                option_byte_i = 8'h00;
	guard_pkg::cpu_access_type cpu;
	logic                      wr_o, ovr_o, req_o;
	logic [7:0]                wd_o, rd_o, ctl_o, d, e;
	logic [19:0]               ad_o, a;
	int                        n_errors = 0;
	int                        checks_done = 0;
	int                        cyc = 0;
	logic [19:0]               grd [4] = '{20'hfff20, 20'hf00f0, 20'hfffd0, 20'hfffe0};
	always #50 clock_i = ~clock_i;
	cpu_model u_cpu (.clock_i(clock_i), .cpu_o(cpu));
	sfr_guard uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .cpu_i(cpu),
		.option_byte_i(option_byte_i), .reg_write_o(wr_o), .reg_addr_o(ad_o),
		.reg_wdata_o(wd_o), .read_override_o(ovr_o), .read_data_o(rd_o),
		.reset_request_o(req_o), .guard_ctrl_o(ctl_o));
	// enable only ever sets; ram guard bits not kept
	function automatic logic [7:0] exp_ctl(input logic [7:0] o, w);
		return (o & 8'h80) | (w & 8'h87);
	endfunction
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// hang guard well above the run length
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(64157));
		repeat (3) @(posedge clock_i);
		#1 reset_n_i = 1'b1;
		`CHK("ctrl", 8'h00, ctl_o)
		u_cpu.acc(1'b0, 1'b0, 1'b1, 20'hf0078, 8'h00);
		`CHK("rd_ovr", 1'b1, ovr_o)
		`CHK("rd_ctrl", 8'h00, rd_o)
		d = 8'($urandom);
		u_cpu.acc(1'b1, 1'b0, 1'b1, 20'hfff20, d);
		`CHK("fwd", 1'b1, wr_o)
		`CHK("wdata", d, wd_o)
		`CHK("addr", 20'hfff20, ad_o)
		u_cpu.acc(1'b1, 1'b0, 1'b1, 20'hf0078, 8'h07);
		`CHK("ctrl", 8'h07, ctl_o)
		u_cpu.acc(1'b0, 1'b0, 1'b1, 20'hf0078, 8'h00);
		`CHK("rd_ctrl", 8'h07, rd_o)
		foreach (grd[i]) begin
			u_cpu.acc(1'b1, 1'b0, 1'b1, grd[i], 8'($urandom));
			`CHK("drop", 1'b0, wr_o)
		end
		u_cpu.acc(1'b1, 1'b0, 1'b1, 20'hf0078, 8'h00);
		u_cpu.acc(1'b1, 1'b0, 1'b0, 20'hf0078, 8'hff);
		`CHK("ctrl", 8'h00, ctl_o)
		a = {6'h03, 14'($urandom)};
		u_cpu.acc(1'b0, 1'b0, 1'b1, a, 8'h00);
		`CHK("gap", 8'hff, ovr_o ? rd_o : 8'h00)
		u_cpu.acc(1'b0, 1'b1, 1'b1, a, 8'h00);
		`CHK("fetch", 1'b1, req_o)
		a = 20'hf2000 + 20'($urandom % 32'hd300);
		u_cpu.acc(1'b0, 1'b0, 1'b1, a, 8'h00);
		`CHK("off", 1'b0, req_o)
		option_byte_i = 8'h10;
		u_cpu.acc(1'b0, 1'b0, 1'b1, a, 8'h00);
		`CHK("force", 1'b1, req_o)
		option_byte_i = 8'h00;
		u_cpu.acc(1'b1, 1'b0, 1'b1, 20'hf0078, 8'h80);
		u_cpu.acc(1'b1, 1'b0, 1'b1, 20'hf0078, 8'h00);
		`CHK("sticky", 8'h80, ctl_o)
		u_cpu.acc(1'b0, 1'b0, 1'b1, a, 8'h00);
		`CHK("detect", 1'b1, req_o)
		e = 8'h80;
		repeat (8) begin
			d = 8'($urandom);
			e = exp_ctl(e, d);
			u_cpu.acc(1'b1, 1'b0, 1'b1, 20'hf0078, d);
			`CHK("ctrl", e, ctl_o)
			u_cpu.acc(1'b0, 1'b0, 1'b1, 20'hf0078, 8'h00);
			`CHK("rd_ctrl", e, rd_o)
		end
		// mid-run reset: guards and the sticky enable must all clear
		reset_n_i = 1'b0;
		repeat (2) @(posedge clock_i);
		#1 reset_n_i = 1'b1;
		`CHK("ctrl", 8'h00, ctl_o)
		u_cpu.acc(1'b1, 1'b0, 1'b1, 20'hfff20, 8'h5a);
		`CHK("fwd", 1'b1, wr_o)
		print_verdict();
	end
endmodule
bind sfr_guard sfr_guard_properties u_props (.clock_i(clock_i), .reset_n_i(reset_n_i),
	.cpu_i(cpu_i), .option_byte_i(option_byte_i), .reg_write_o(reg_write_o),
	.reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .read_override_o(read_override_o),
	.read_data_o(read_data_o), .reset_request_o(reset_request_o),
	.guard_ctrl_o(guard_ctrl_o));

// >>> tb/sfr_guard_properties.sv
/* checker for the guard ports
   assumes the default guard table and region map */
`timescale 1ns/100ps
module sfr_guard_properties (
	// clock, reset and inputs
	input wire logic                      clock_i,
	input wire logic                      reset_n_i,
	input wire guard_pkg::cpu_access_type cpu_i,
	input wire logic [7:0]                option_byte_i,
	// outputs watched
	input wire logic                      reg_write_o,
	input wire logic [19:0]               reg_addr_o,
	input wire logic [7:0]                reg_wdata_o,
	input wire logic                      read_override_o,
	input wire logic [7:0]                read_data_o,
	input wire logic                      reset_request_o,
	input wire logic [7:0]                guard_ctrl_o
);
	// ----------------------------------------
	// access classes
	// ----------------------------------------
	logic wr, gap, bad;
	assign wr = cpu_i.valid && cpu_i.write;
	assign gap = cpu_i.valid && cpu_i.addr > 20'h0bfff && cpu_i.addr <= 20'h0ffff;
	// only the span below ram; the rest overlaps control space
	assign bad = cpu_i.valid && cpu_i.addr >= 20'hf2000 && cpu_i.addr < 20'hff300;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	a_port_drop: assert property (wr && cpu_i.addr == 20'hfff20 && guard_ctrl_o[2]
		|=> !reg_write_o) else $error("port write passed");
	a_irq_drop: assert property (wr && cpu_i.addr == 20'hfffd0 && guard_ctrl_o[1]
		|=> !reg_write_o) else $error("irq write passed");
	a_clkv_drop: assert property (wr && cpu_i.addr == 20'hf00f0 && guard_ctrl_o[0]
		|=> !reg_write_o) else $error("clock write passed");
	a_reset_clear: assert property ($rose(reset_n_i) |-> guard_ctrl_o == 8'h00)
		else $error("guards not clear");
	a_ctrl_byte_only: assert property (wr && !cpu_i.byte_access && cpu_i.addr == 20'hf0078
		|=> $stable(guard_ctrl_o)) else $error("wide write took");
	a_ctrl_readback: assert property (cpu_i.valid && !cpu_i.write && cpu_i.byte_access
		&& cpu_i.addr == 20'hf0078 |=> read_override_o && read_data_o == $past(guard_ctrl_o))
		else $error("control readback wrong");
	a_detect_req: assert property (bad && (guard_ctrl_o[7] || option_byte_i[4])
		|=> reset_request_o) else $error("no reset request");
	a_enable_sticky: assert property (guard_ctrl_o[7] |=> guard_ctrl_o[7])
		else $error("enable cleared");
	a_gap_read: assert property (gap && !cpu_i.write && !cpu_i.fetch
		|=> read_override_o && read_data_o == 8'hff) else $error("gap read wrong");
	a_gap_fetch: assert property (gap && cpu_i.fetch |=> reset_request_o)
		else $error("gap fetch ran");
	c_fetch: cover property (gap && cpu_i.fetch);
	c_drop: cover property (wr && cpu_i.addr == 20'hfffd0 && guard_ctrl_o[1]);
	c_force: cover property (bad && option_byte_i[4]);
endmodule
